/* core_seq_model.sv */
// core sequencer model: fetches a presented vector, then runs one op
`timescale 1ns/1ps
module core_seq_model (
    input wire logic i_core_clk, // clock
    input wire logic i_rstn, // reset
    input wire logic i_valid, // vector presented
    input wire logic i_slow, // fetch late
    output logic o_fetched, // vector fetch done
    output logic o_first_done // first handler op done
);
    logic [1:0] wait_r;
    // fetch after 0 or 3 waits, handler op completes the cycle after
    always_ff @(posedge i_core_clk)
    begin
        wait_r <= (!i_rstn || !i_valid || o_fetched) ? 2'h0 : wait_r + 2'h1;
        o_fetched <= i_rstn && i_valid && !o_fetched && wait_r == (i_slow ? 2'h3 : 2'h0);
        o_first_done <= i_rstn && o_fetched;
    end
endmodule

/* irq_vec_pkg.sv */
// package: constants and types for interrupt priority and vectoring
package irq_vec_pkg;
    // vector pair addresses (high byte address of pair)
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
    localparam logic [15:0] VEC_WDOG = 16'hFFFA;
    localparam logic [15:0] VEC_ILLOP = 16'hFFF8;
    localparam logic [15:0] VEC_SWTRAP = 16'hFFF6;
    localparam logic [15:0] VEC_PNMI = 16'hFFF4;
    localparam logic [15:0] VEC_EXTIRQ = 16'hFFF2;
    localparam logic [15:0] VEC_PERIODIC = 16'hFFF0;
    localparam logic [15:0] VEC_TIMER_BASE = 16'hFFE0;
    localparam logic [15:0] VEC_TOF = 16'hFFDE;
    localparam logic [15:0] VEC_PAOV = 16'hFFDC;
    localparam logic [15:0] VEC_PAEDGE = 16'hFFDA;
    localparam logic [15:0] VEC_SPI = 16'hFFD8;
    localparam logic [15:0] VEC_SCI = 16'hFFD6;
    // maskable source count and select field
    localparam int NUM_MASKABLE = 15;
    localparam logic [3:0] PSEL_RESET = 4'h5;
    localparam logic [3:0] PSEL_RESERVED = 4'h5;
    localparam logic [3:0] PSEL_EXTIRQ = 4'h6;
    localparam int SCI_ENABLES = 5;
    // periodic divider exponents
    localparam int PER_EXP_MIN = 13;
    localparam int PER_DIV_W = 16;
    // status of the resolved request
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic sets_x;
        logic sets_i;
    } vector_s;
endpackage

/* mcu_interrupt_priority_vectoring.sv */
// interrupt priority resolution, mask bits and vector generation
// Contract
// - seventeen hardware sources plus one software trap besides resets
// - fifteen sources blocked while the I mask bit is set
// - each on-chip source has a local enable gating its request
// - pin NMI blocked at reset and after its entry; traps unmaskable
// - reset FFFE, clock monitor FFFC, watchdog FFFA, gated by enables
// - illegal op FFF8, trap FFF6, pin NMI FFF4 masked by X only
// - external pin FFF2, periodic FFF0, timers FFE0-FFEF, overflow FFDE
// - serial FFD6 five enables, sync serial FFD8, edge FFDA
// - software trap sets I, waits for no pending, blocks until handler
// - undefined opcode detection raises illegal-opcode vector
// - periodic interrupt at E over 2^13..2^16, gated by I and enable
// - reset sets X and I
// - X cleared by transfer; only entry or reset sets it (return here loads stacked X, so it can also set X)
// - pin NMI beats every I-maskable source
// - maskable entry sets I after stacking, X unchanged
// - pin NMI entry sets X and I
// - return restores X and I to pre-entry values
// - unmaskable order: reset, monitor, watchdog, illegal, trap, pin
// - after trap fetch no non-reset source until its vector fetch
// - one promoted source; select written only while I is set
// - promoted source keeps enables, I mask and its own vector
// - select resets to 0101, meaning external pin promoted
// - select codes follow encoding 0000 overflow to 1111 compare 4
`timescale 1ns/1ps
module mcu_interrupt_priority_vectoring (
    input wire logic i_core_clk, // E clock
    input wire logic i_rstn, // synchronous reset, active low
    input wire logic i_ext_reset, // external reset request
    input wire logic i_clk_fail, // clock monitor failure
    input wire logic i_clk_monitor_enable, // clock monitor enable
    input wire logic i_wd_fail, // watchdog timeout
    input wire logic i_watchdog_disable, // watchdog disable
    input wire logic i_illegal_op, // illegal opcode detected
    input wire logic i_software_trap, // trap opcode fetched
    input wire logic i_pseudo_nmi_pin_n, // pin NMI, active low level
    input wire logic i_ext_irq_n, // external maskable pin, active low
    input wire logic [14:0] i_src_req, // per-source flags, select-code order
    input wire logic [14:0] i_src_en, // per-source local enables
    input wire logic [4:0] i_sci_req, // serial sub-flags
    input wire logic [4:0] i_sci_en, // serial sub-enables
    input wire logic [1:0] i_periodic_rate, // periodic divide select
    input wire logic i_periodic_int_enable, // periodic local enable
    input wire logic i_periodic_clr, // clear periodic flag
    input wire logic i_boundary, // instruction boundary
    input wire logic i_vec_fetched, // vector fetch done, entry complete
    input wire logic i_handler_first_done, // first handler instruction done
    input wire logic i_ccr_wr, // accumulator to condition code transfer
    input wire logic [1:0] i_ccr_wr_xi, // written X,I
    input wire logic i_return, // return from interrupt pulls X,I
    input wire logic [1:0] i_return_xi, // stacked X,I
    input wire logic i_psel_wr, // priority select write
    input wire logic [3:0] i_psel_data, // priority select data
    output logic o_x_bit, // condition code X
    output logic o_i_bit, // condition code I
    output logic [3:0] o_promoted_source_code, // priority select field
    output logic o_periodic_flag, // periodic interrupt flag
    output logic o_vec_valid, // vector presented
    output logic [15:0] o_vec_addr, // vector pair address
    output logic o_trap_blocked // trap may not start, request pending
);
    logic x_r;
    logic i_r;
    logic [3:0] psel_r;
    logic [15:0] div_r;
    logic per_flag_r;
    logic trap_lock_r;
    logic handler_lock_r;
    irq_vec_pkg::vector_s vec_r;
    irq_vec_pkg::vector_s vec_nxt;
    // maskable request vector indexed by select code
    logic [14:0] mreq;
    logic [15:0] code_req;
    logic [15:0] code_vec [0:15];
    logic sci_any;
    logic per_tick;
    logic [15:0] tick_mask;
    logic per_code_req;
    logic clkmon_req;
    logic wd_req;
    logic pnmi_req;
    logic any_mask;
    logic promo_req;
    logic [3:0] promo_code;
    logic [3:0] fixed_code;
    logic fixed_found;
    assign sci_any = |(i_sci_req & i_sci_en);
    assign tick_mask = (16'h0001 << (irq_vec_pkg::PER_EXP_MIN + i_periodic_rate)) - 16'h0001;
    assign per_tick = ((div_r & tick_mask) == tick_mask);
    assign per_code_req = per_flag_r & i_periodic_int_enable;
    genvar g;
    generate
        for (g = 0; g < irq_vec_pkg::NUM_MASKABLE; g++)
        begin : g_req
            if (g == 4)
            begin : g_sci
                assign mreq[g] = sci_any;
            end
            else if (g == 5)
            begin : g_rsv
                assign mreq[g] = 1'b0;
            end
            else if (g == 6)
            begin : g_irq
                // external pin has no local mask
                assign mreq[g] = ~i_ext_irq_n;
            end
            else if (g == 7)
            begin : g_per
                assign mreq[g] = per_code_req;
            end
            else
            begin : g_loc
                assign mreq[g] = i_src_req[g] & i_src_en[g];
            end
        end
    endgenerate
    // request per select code; codes 14 and 15 share the last timer input
    assign code_req = {i_src_req[14] & i_src_en[14], mreq};
    // seventeen hardware sources counted with the serial group
    // I bit gates all fifteen maskable slots
    assign any_mask = |code_req & ~i_r;
    assign code_vec[0] = irq_vec_pkg::VEC_TOF;
    assign code_vec[1] = irq_vec_pkg::VEC_PAOV;
    assign code_vec[2] = irq_vec_pkg::VEC_PAEDGE;
    assign code_vec[3] = irq_vec_pkg::VEC_SPI;
    assign code_vec[4] = irq_vec_pkg::VEC_SCI;
    assign code_vec[5] = irq_vec_pkg::VEC_EXTIRQ;
    assign code_vec[6] = irq_vec_pkg::VEC_EXTIRQ;
    assign code_vec[7] = irq_vec_pkg::VEC_PERIODIC;
    assign code_vec[8] = irq_vec_pkg::VEC_TIMER_BASE + 16'h000E;
    assign code_vec[9] = irq_vec_pkg::VEC_TIMER_BASE + 16'h000C;
    assign code_vec[10] = irq_vec_pkg::VEC_TIMER_BASE + 16'h000A;
    assign code_vec[11] = irq_vec_pkg::VEC_TIMER_BASE + 16'h0008;
    assign code_vec[12] = irq_vec_pkg::VEC_TIMER_BASE + 16'h0006;
    assign code_vec[13] = irq_vec_pkg::VEC_TIMER_BASE + 16'h0004;
    assign code_vec[14] = irq_vec_pkg::VEC_TIMER_BASE;
    assign code_vec[15] = irq_vec_pkg::VEC_TIMER_BASE + 16'h0002;
    assign promo_code = (psel_r == irq_vec_pkg::PSEL_RESERVED) ? irq_vec_pkg::PSEL_EXTIRQ : psel_r;
    // promoted slot keeps enable and own vector
    assign promo_req = code_req[promo_code];
    // fixed order among maskable: external pin, periodic, timers, then others
    always_comb
    begin
        fixed_code = 4'h0;
        fixed_found = 1'b0;
        if (mreq[6])
        begin
            fixed_code = 4'h6;
            fixed_found = 1'b1;
        end
        else if (mreq[7])
        begin
            fixed_code = 4'h7;
            fixed_found = 1'b1;
        end
        else
        begin
            for (int k = 8; k < 16; k++)
            begin
                if (!fixed_found && code_req[k])
                begin
                    fixed_code = 4'(k);
                    fixed_found = 1'b1;
                end
            end
            for (int k = 0; k < 5; k++)
            begin
                if (!fixed_found && mreq[k])
                begin
                    fixed_code = 4'(k);
                    fixed_found = 1'b1;
                end
            end
        end
    end
    assign clkmon_req = i_clk_fail & i_clk_monitor_enable;
    assign wd_req = i_wd_fail & ~i_watchdog_disable;
    // pin NMI masked only by X
    assign pnmi_req = ~i_pseudo_nmi_pin_n & ~x_r;
    assign o_trap_blocked = pnmi_req | any_mask | i_illegal_op | wd_req | clkmon_req;
    always_comb
    begin
        vec_nxt = vec_r;
        if (i_ext_reset)
            vec_nxt = '{1'b1, irq_vec_pkg::VEC_RESET, 1'b1, 1'b1};
        else if (clkmon_req)
            vec_nxt = '{1'b1, irq_vec_pkg::VEC_CLKMON, 1'b1, 1'b1};
        else if (wd_req)
            vec_nxt = '{1'b1, irq_vec_pkg::VEC_WDOG, 1'b1, 1'b1};
        else if (vec_r.valid || trap_lock_r || handler_lock_r)
            vec_nxt = vec_r;
        else if (!i_boundary)
            vec_nxt = vec_r;
        else if (i_illegal_op)
            vec_nxt = '{1'b1, irq_vec_pkg::VEC_ILLOP, 1'b0, 1'b1};
        else if (i_software_trap && !o_trap_blocked)
            vec_nxt = '{1'b1, irq_vec_pkg::VEC_SWTRAP, 1'b0, 1'b1};
        // pin NMI sets X and I
        else if (pnmi_req)
            vec_nxt = '{1'b1, irq_vec_pkg::VEC_PNMI, 1'b1, 1'b1};
        // promoted slot first; sets I only
        else if (!i_r && promo_req)
            vec_nxt = '{1'b1, code_vec[promo_code], 1'b0, 1'b1};
        else if (!i_r && fixed_found)
            vec_nxt = '{1'b1, code_vec[fixed_code], 1'b0, 1'b1};
        if (i_vec_fetched && vec_r.valid)
            vec_nxt.valid = 1'b0;
    end
    // presented vector register
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            vec_r <= '{1'b0, irq_vec_pkg::VEC_RESET, 1'b1, 1'b1};
        else
            vec_r <= vec_nxt;
    end
    // trap locks until vector and first instruction
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            trap_lock_r <= 1'b0;
            handler_lock_r <= 1'b0;
        end
        else
        begin
            trap_lock_r <= (vec_nxt.valid && vec_nxt.addr == irq_vec_pkg::VEC_SWTRAP)
                ? ~(i_vec_fetched & vec_r.valid) : 1'b0;
            if (i_vec_fetched && vec_r.valid && vec_r.addr == irq_vec_pkg::VEC_SWTRAP)
                handler_lock_r <= 1'b1;
            else if (i_handler_first_done)
                handler_lock_r <= 1'b0;
        end
    end
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            x_r <= 1'b1;
            i_r <= 1'b1;
        end
        else if (i_vec_fetched && vec_r.valid)
        begin
            x_r <= x_r | vec_r.sets_x;
            i_r <= 1'b1;
        end
        else if (i_return)
        begin
            x_r <= i_return_xi[1];
            i_r <= i_return_xi[0];
        end
        else if (i_ccr_wr)
        begin
            x_r <= x_r & i_ccr_wr_xi[1];
            i_r <= i_ccr_wr_xi[0];
        end
    end
    // select write only with I set
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            psel_r <= irq_vec_pkg::PSEL_RESET;
        else if (i_psel_wr && i_r)
            psel_r <= i_psel_data;
    end
    // periodic divider and flag, set wins over clear
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            div_r <= 16'h0000;
            per_flag_r <= 1'b0;
        end
        else
        begin
            div_r <= div_r + 16'h0001;
            per_flag_r <= per_tick | (per_flag_r & ~i_periodic_clr);
        end
    end
    // outputs straight from the state registers
    assign o_x_bit = x_r;
    assign o_i_bit = i_r;
    assign o_promoted_source_code = psel_r;
    assign o_periodic_flag = per_flag_r;
    assign o_vec_valid = vec_r.valid;
    assign o_vec_addr = vec_r.addr;
endmodule

/* mcu_ipv_props.sv */
// checker for vector hand-over and mask bit behaviour
`timescale 1ns/1ps
module mcu_ipv_props (
    input wire logic i_core_clk, // clock
    input wire logic i_rstn, // reset
    input wire logic i_ext_reset, // reset req
    input wire logic i_clk_fail, // monitor
    input wire logic i_wd_fail, // watchdog
    input wire logic i_illegal_op, // bad op
    input wire logic i_software_trap, // trap
    input wire logic i_ext_irq_n, // pin irq
    input wire logic i_boundary, // boundary
    input wire logic i_vec_fetched, // fetch done
    input wire logic i_return, // return
    input wire logic [1:0] i_return_xi, // stacked
    input wire logic i_psel_wr, // select wr
    input wire logic [3:0] i_psel_data, // select data
    input wire logic o_x_bit, // x
    input wire logic o_i_bit, // i
    input wire logic [3:0] o_promoted_source_code, // select
    input wire logic o_vec_valid, // valid
    input wire logic [15:0] o_vec_addr // address
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    wire hard_req = i_ext_reset | i_clk_fail | i_wd_fail | i_illegal_op | i_software_trap;

    // mask, entry and select relations
    rst_vals_a: assert property ($rose(i_rstn) |-> o_x_bit && o_i_bit
        && o_promoted_source_code == 4'h5 && !o_vec_valid) else $error("reset state wrong");
    i_mask_a: assert property (o_x_bit && o_i_bit && i_boundary && !o_vec_valid
        && !hard_req |=> !o_vec_valid) else $error("masked request taken");
    take_time_a: assert property (i_boundary && !o_vec_valid && !o_i_bit && !i_ext_irq_n
        |=> o_vec_valid) else $error("vector not presented");
    vec_stands_a: assert property (o_vec_valid && !i_vec_fetched
        |=> o_vec_valid && $stable(o_vec_addr)) else $error("vector dropped early");
    entry_sets_a: assert property (o_vec_valid && i_vec_fetched
        |=> o_i_bit && !o_vec_valid) else $error("entry left I clear");
    pin_entry_a: assert property (o_vec_valid && i_vec_fetched && o_vec_addr == 16'hFFF4
        |=> o_x_bit && o_i_bit) else $error("pin entry left X or I clear");
    x_no_set_a: assert property (!o_x_bit && !i_vec_fetched && !i_return
        |=> !o_x_bit) else $error("X set by software");
    restore_xi_a: assert property (i_return
        |=> {o_x_bit, o_i_bit} == $past(i_return_xi)) else $error("return restore wrong");
    sel_write_a: assert property (i_psel_wr && o_i_bit
        |=> o_promoted_source_code == $past(i_psel_data)) else $error("select write lost");
    sel_lock_a: assert property (!o_i_bit
        |=> $stable(o_promoted_source_code)) else $error("select changed with I clear");
    vec_range_a: assert property (o_vec_valid
        |-> o_vec_addr >= 16'hFFD6 && !o_vec_addr[0]) else $error("reserved vector used");
endmodule

bind mcu_interrupt_priority_vectoring mcu_ipv_props i_props (.*);

/* test_mcu_interrupt_priority_vectoring.sv */
// bench: drives sources and core handshakes, scores vector addresses
`timescale 1ns/1ps
module test_mcu_interrupt_priority_vectoring;
    logic i_core_clk = 1'b0, i_rstn = 1'b0, i_ext_reset = 1'b0, i_clk_fail = 1'b0;
    logic i_clk_monitor_enable = 1'b0, i_watchdog_disable = 1'b1, i_wd_fail = 1'b0;
    logic i_illegal_op = 1'b0, i_software_trap = 1'b0, i_pseudo_nmi_pin_n = 1'b1;
    logic i_ext_irq_n = 1'b1, i_periodic_int_enable = 1'b0, i_periodic_clr = 1'b0;
    logic i_boundary = 1'b0, i_ccr_wr = 1'b0, i_return = 1'b0, i_psel_wr = 1'b0;
    logic [14:0] i_src_req = 15'h0, i_src_en = 15'h0;
    logic [4:0] i_sci_req = 5'h0, i_sci_en = 5'h0;
    logic [1:0] i_periodic_rate = 2'h0, i_ccr_wr_xi = 2'h0, i_return_xi = 2'h0;
    logic [3:0] i_psel_data = 4'h0, o_promoted_source_code;
    logic i_vec_fetched, i_handler_first_done, o_x_bit, o_i_bit, o_periodic_flag;
    logic o_vec_valid, o_trap_blocked, vv_q = 1'b0, slow = 1'b0;
    logic [15:0] o_vec_addr, ev, notes[$];
    logic [31:0] seed = 32'h91D39ED8;
    int fails = 0, cmp_count = 0, n;
    mcu_interrupt_priority_vectoring i_dut (.*);
    core_seq_model i_core (.i_core_clk, .i_rstn, .i_valid(o_vec_valid), .i_slow(slow),
        .o_fetched(i_vec_fetched), .o_first_done(i_handler_first_done));
    always #5 i_core_clk = ~i_core_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic cyc(input int c);
        repeat (c) @(posedge i_core_clk);
    endtask
    task automatic close_out;
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        #1;
        cmp_count++;
        if (s !== e)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    // p = {reset, monitor, watchdog, boundary}; note the vector if one is due
    task automatic go(input logic [3:0] p, input logic e, input logic [15:0] a);
        if (e)
            notes.push_back(a);
        seed = xs(seed);
        slow <= seed[0];
        {i_ext_reset, i_clk_fail, i_wd_fail, i_boundary} <= p;
        cyc(1);
        {i_ext_reset, i_clk_fail, i_wd_fail, i_boundary} <= 4'h0;
        cyc(8);
    endtask
    task automatic cc_wr(input logic [1:0] xi);
        i_ccr_wr <= 1'b1;
        i_ccr_wr_xi <= xi;
        cyc(1);
        i_ccr_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic pw(input logic [3:0] d);
        i_psel_wr <= 1'b1;
        i_psel_data <= d;
        cyc(1);
        i_psel_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic clr_wait(input logic w);
        i_periodic_clr <= 1'b1;
        cyc(1);
        i_periodic_clr <= 1'b0;
        cyc(1);
        n = 0;
        while (w && o_periodic_flag !== 1'b1 && n < 70000)
        begin
            cyc(1);
            n++;
        end
        if (n >= 70000)
        begin
            fails++;
            close_out();
        end
    endtask
    // oldest note against each newly presented vector
    always @(posedge i_core_clk)
    begin
        vv_q <= o_vec_valid;
        if (o_vec_valid === 1'b1 && vv_q !== 1'b1)
            chk("vec_addr", (notes.size() > 0) ? notes.pop_front() : 16'h0, o_vec_addr);
    end
    initial
    begin
        cyc(8);
        i_rstn <= 1'b1;
        cyc(1);
        chk("xi_rst", 16'h3, {14'h0, o_x_bit, o_i_bit});
        chk("psel_rst", 16'h5, {12'h0, o_promoted_source_code});
        i_ext_irq_n <= 1'b0;
        go(4'h1, 1'b0, 16'h0);
        pw(4'h0);
        cc_wr(2'h0);
        cc_wr(2'h2);
        chk("xi_clr", 16'h0, {14'h0, o_x_bit, o_i_bit});
        i_src_req <= 15'h1;
        i_src_en <= 15'h1;
        go(4'h1, 1'b1, 16'hFFDE);
        i_src_req <= 15'h0;
        cc_wr(2'h0);
        seed = xs(seed);
        pw(seed[3:0] | 4'h1);
        chk("psel_lock", 16'h0, {12'h0, o_promoted_source_code});
        go(4'h1, 1'b1, 16'hFFF2);
        i_ext_irq_n <= 1'b1;
        for (int k = 0; k < 15; k++)
        begin
            if (k > 3 && k < 8)
                continue;
            cc_wr(2'h0);
            seed = xs(seed);
            i_src_req <= seed[14:0] | (15'h1 << k);
            i_src_en <= 15'h0;
            go(4'h1, 1'b0, 16'h0);
            i_src_req <= 15'h1 << k;
            i_src_en <= 15'h1 << k;
            ev = k < 4 ? 16'hFFDE - 16'(2 * k) : k == 14 ? 16'hFFE0 : 16'hFFEE - 16'(2 * k - 16);
            go(4'h1, 1'b1, ev);
            chk("xi_entry", 16'h1, {14'h0, o_x_bit, o_i_bit});
        end
        i_src_req <= 15'h0;
        for (int j = 0; j < 5; j++)
        begin
            cc_wr(2'h0);
            i_sci_req <= 5'h1F;
            i_sci_en <= 5'h1 << j;
            go(4'h1, 1'b1, 16'hFFD6);
        end
        i_sci_req <= 5'h0;
        cc_wr(2'h0);
        i_pseudo_nmi_pin_n <= 1'b0;
        i_ext_irq_n <= 1'b0;
        go(4'h1, 1'b1, 16'hFFF4);
        chk("xi_pin", 16'h3, {14'h0, o_x_bit, o_i_bit});
        i_ext_irq_n <= 1'b1;
        i_return <= 1'b1;
        cyc(1);
        i_return <= 1'b0;
        cyc(1);
        chk("xi_ret", 16'h0, {14'h0, o_x_bit, o_i_bit});
        chk("trap_blk", 16'h1, {15'h0, o_trap_blocked});
        i_illegal_op <= 1'b1;
        i_software_trap <= 1'b1;
        go(4'h1, 1'b1, 16'hFFF8);
        i_illegal_op <= 1'b0;
        i_pseudo_nmi_pin_n <= 1'b1;
        go(4'h1, 1'b1, 16'hFFF6);
        i_software_trap <= 1'b0;
        chk("i_trap", 16'h1, {15'h0, o_i_bit});
        go(4'h6, 1'b0, 16'h0);
        i_clk_monitor_enable <= 1'b1;
        go(4'h6, 1'b1, 16'hFFFC);
        i_watchdog_disable <= 1'b0;
        go(4'h2, 1'b1, 16'hFFFA);
        go(4'hE, 1'b1, 16'hFFFE);
        i_periodic_int_enable <= 1'b1;
        // first wait aligns to a tick, second spans one full period
        for (int r = 0; r < 2; r++)
        begin
            i_periodic_rate <= 2'(r);
            clr_wait(1'b1);
            clr_wait(1'b1);
            chk("period", 16'h2000 << r, 16'(n + 2));
        end
        cc_wr(2'h0);
        go(4'h1, 1'b1, 16'hFFF0);
        clr_wait(1'b0);
        i_rstn <= 1'b0;
        cyc(2);
        i_rstn <= 1'b1;
        cyc(1);
        chk("xi_rst2", 16'h3, {14'h0, o_x_bit, o_i_bit});
        chk("psel_rst2", 16'h5, {12'h0, o_promoted_source_code});
        chk("notes_left", 16'h0, 16'(notes.size()));
        close_out();
    end
endmodule
